// ### design/lcd_vac_timing.sv
// Vertical drive and AC-conversion timing generator with a Wishbone
// register file, line reference and half-dot horizontal phase shift.
// Assumes a classic Wishbone master on i_mclk and asynchronous sync pins.
`timescale 1ns/1ps
`include "lcd_vac_consts.svh"

module lcd_vac_timing #(
	parameter logic [10:0] HCK_HALF_DOTS = 11'h006,
	parameter logic [10:0] ENB_DOTS      = 11'h010
) (
	// Clock and reset
	input  wire logic          i_mclk,
	input  wire logic          i_reset,
	// Wishbone slave
	input  wire logic          i_wb_cyc,
	input  wire logic          i_wb_stb,
	input  wire logic          i_wb_we,
	input  wire logic [15:0]   i_wb_adr,
	input  wire logic [31:0]   i_wb_dat,
	input  wire logic [3:0]    i_wb_sel,
	output logic      [31:0]   o_wb_dat,
	output logic               o_wb_ack,
	// Sync and direction pins
	input  wire logic          i_horiz_sync_input,
	input  wire logic          i_vsync,
	input  wire logic          i_scan_direction,
	// Horizontal transfer pulses
	output logic               o_horiz_start_pulse,
	output logic               o_precharge_start_pulse,
	output logic               o_horiz_clock_a,
	output logic               o_horiz_clock_b,
	output logic               o_data_clock_a,
	output logic               o_data_clock_b,
	// Vertical and AC-conversion pulses
	output logic               o_vert_start_pulse,
	output logic               o_vert_clock_pulse,
	output logic               o_line_enable_pulse,
	output logic               o_frame_inversion_pulse,
	output logic               o_frame_inversion_complement
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic pos_hit(
		input logic [`HCOUNT_W-1:0] cnt,
		input logic [`HCOUNT_W-1:0] pos
	);
		return cnt == pos;
	endfunction : pos_hit

	// Returns the driven level of a pulse given its polarity controls.
	function automatic logic pol_out(
		input logic raw,
		input logic pol,
		input logic fix,
		input logic scan_direction
	);
		logic positive;
		positive = fix ? pol : (pol == scan_direction);
		return positive ? raw : ~raw;
	endfunction : pol_out

	////////////////////////////////////////////////////////////////////////
	// Submodules.

	lcd_vac_line_if line ();

	lcd_vac_pkg::core_s r;
	lcd_vac_pkg::core_s n;

	logic [5:0] h_raw;
	logic [5:0] h_shifted;

	lcd_vac_lineref u_lineref (
		.i_mclk             (i_mclk),
		.i_reset            (i_reset),
		.i_horiz_sync_input (i_horiz_sync_input),
		.i_vsync            (i_vsync),
		.i_scan_direction   (i_scan_direction),
		.line               (line)
	);

	lcd_vac_hphase u_hphase (
		.i_mclk   (i_mclk),
		.i_reset  (i_reset),
		.i_pulses (h_raw),
		.i_shp    (r.sample_hold_phase),
		.o_pulses (h_shifted)
	);

	////////////////////////////////////////////////////////////////////////
	// Horizontal pulse shapes, before the half-dot shift.

	logic hst_raw;
	logic pst_raw;

	always_comb begin
		hst_raw = line.hcount < (HCK_HALF_DOTS << 1);
		pst_raw = (line.hcount >= HCK_HALF_DOTS) &&
			(line.hcount < (HCK_HALF_DOTS + (HCK_HALF_DOTS << 1)));
		h_raw = {~r.hck, r.hck, ~r.hck, r.hck, pst_raw, hst_raw};
	end

	////////////////////////////////////////////////////////////////////////
	// Register file, vertical timing and output gating.

	logic [`HCOUNT_W-1:0] vst_at;
	logic [`HCOUNT_W-1:0] vck_at;
	logic [`HCOUNT_W-1:0] inv_at;
	logic                 vst_hit;
	logic                 vck_hit;
	logic                 inv_hit;
	logic                 frame_term;
	logic                 line_term;

	always_comb begin
		vst_at = {r.vst_pos, 1'b0} + `HCOUNT_W'(2);
		vck_at = {1'b0, r.vck_pos} + `HCOUNT_W'(1);
		inv_at = {1'b0, r.inv_pos} + `HCOUNT_W'(1);
		vst_hit = line.dot_en && pos_hit(line.hcount, vst_at);
		vck_hit = line.dot_en && pos_hit(line.hcount, vck_at);
		inv_hit = line.dot_en && pos_hit(line.hcount, inv_at);
		// Modes 00 1F/1H, 01 2F/1H, 10 1F, 11 2F.
		frame_term = r.mode[`BIT_MODE_LO] ? r.frame_cnt[1] :
			r.frame_cnt[0];
		line_term = ~r.mode[`BIT_MODE_HI] & r.line_par;
	end

	logic [13:0] idx;
	logic [7:0]  rd;
	logic        wr;

	always_comb begin
		n = r;
		idx = i_wb_adr[15:2];
		rd = `RST_BYTE;
		wr = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && r.wb_ack;

		if (idx == `IDX_TRANS_LINK) begin
			rd = {7'h00, r.share};
		end else if (idx == `IDX_POL_MODE) begin
			rd = {4'h0, r.vck_pol, r.vst_pol, r.mode};
		end else if (idx == `IDX_POL_FIX) begin
			rd = {6'h00, r.vck_fix, r.vst_fix};
		end else if (idx == `IDX_INV_POS_A) begin
			rd = r.inv_pos[7:0];
		end else if (idx == `IDX_INV_POS_B) begin
			rd = {6'h00, r.inv_pos[9:8]};
		end else if (idx == `IDX_SH_PHASE) begin
			rd = {2'h0, r.sample_hold_phase};
		end else if (idx == `IDX_VPOS_UPPER) begin
			rd = {4'h0, r.vst_pos[9:8], r.vck_pos[9:8]};
		end else if (idx == `IDX_VCK_POS_LOW) begin
			rd = r.vck_pos[7:0];
		end else if (idx == `IDX_VST_POS_LOW) begin
			rd = r.vst_pos[7:0];
		end else if (idx == `IDX_GATE_A) begin
			rd = {6'h00, r.comp_oe, r.inv_oe};
		end else if (idx == `IDX_GATE_B) begin
			rd = {7'h00, r.output_gate_b};
		end else if (idx == `IDX_STATUS) begin
			rd = {4'h0, line.scan_dir, r.frp_raw, r.vck_raw, r.vst_raw};
		end

		// One-wait-state answer; unmapped addresses read zero.
		n.wb_ack = i_wb_cyc && i_wb_stb && !r.wb_ack;
		if (n.wb_ack && !i_wb_we) begin
			n.wb_dat = {24'h000000, rd};
		end

		if (wr) begin
			if (idx == `IDX_TRANS_LINK) begin
				n.share = i_wb_dat[`BIT_SHARE];
			end else if (idx == `IDX_POL_MODE) begin
				n.mode = i_wb_dat[`BIT_MODE_HI:`BIT_MODE_LO];
				n.vst_pol = i_wb_dat[`BIT_VST_POL];
				n.vck_pol = i_wb_dat[`BIT_VCK_POL];
			end else if (idx == `IDX_POL_FIX) begin
				n.vst_fix = i_wb_dat[`BIT_VST_FIX];
				n.vck_fix = i_wb_dat[`BIT_VCK_FIX];
			end else if (idx == `IDX_INV_POS_A) begin
				n.inv_pos[7:0] = i_wb_dat[7:0];
			end else if (idx == `IDX_INV_POS_B) begin
				n.inv_pos[9:8] = i_wb_dat[1:0];
			end else if (idx == `IDX_SH_PHASE) begin
				n.sample_hold_phase = i_wb_dat[5:0];
			end else if (idx == `IDX_VPOS_UPPER) begin
				n.vck_pos[9:8] = i_wb_dat[1:0];
				n.vst_pos[9:8] = i_wb_dat[3:2];
			end else if (idx == `IDX_VCK_POS_LOW) begin
				n.vck_pos[7:0] = i_wb_dat[7:0];
			end else if (idx == `IDX_VST_POS_LOW) begin
				n.vst_pos[7:0] = i_wb_dat[7:0];
			end else if (idx == `IDX_GATE_A) begin
				n.inv_oe = i_wb_dat[`BIT_INV_OE];
				n.comp_oe = i_wb_dat[`BIT_COMP_OE];
			end else if (idx == `IDX_GATE_B) begin
				n.output_gate_b = i_wb_dat[`BIT_VOE];
			end
		end

		// Horizontal clock restarts low at every line reference.
		if (line.line_ref) begin
			n.hck_cnt = 11'h000;
			n.hck = 1'b0;
		end else if (line.dot_en) begin
			if (r.hck_cnt >= (HCK_HALF_DOTS - 11'h001)) begin
				n.hck_cnt = 11'h000;
				n.hck = ~r.hck;
			end else begin
				n.hck_cnt = r.hck_cnt + 11'h001;
			end
		end

		// Vertical start is one line wide, starting on the first line
		// after a frame edge.
		if (vst_hit) begin
			n.vst_raw = r.vst_pend;
			n.vst_pend = 1'b0;
		end
		if (line.line_ref) begin
			n.line_par = ~r.line_par;
			if (line.frame_line) begin
				n.vst_pend = 1'b1;
				n.frame_cnt = r.frame_cnt + 2'h1;
			end
		end

		if (inv_hit) begin
			n.frp_raw = frame_term ^ line_term;
		end
		if (r.share ? inv_hit : vck_hit) begin
			n.vck_raw = ~r.vck_raw;
		end

		n.vst_out = r.output_gate_b &
			pol_out(r.vst_raw, r.vst_pol, r.vst_fix, line.scan_dir);
		n.vck_out = r.output_gate_b &
			pol_out(r.vck_raw, r.vck_pol, r.vck_fix, line.scan_dir);
		n.enb_out = r.output_gate_b & (line.hcount < ENB_DOTS);
		n.frp_out = r.inv_oe & r.frp_raw;
		n.frame_inversion_complement_out = r.comp_oe & ~r.frp_raw;
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			r <= '{mode: `RST_MODE, default: '0};
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign o_wb_dat = r.wb_dat;
	assign o_wb_ack = r.wb_ack;
	assign o_horiz_start_pulse = h_shifted[0];
	assign o_precharge_start_pulse = h_shifted[1];
	assign o_horiz_clock_a = h_shifted[2];
	assign o_horiz_clock_b = h_shifted[3];
	assign o_data_clock_a = h_shifted[4];
	assign o_data_clock_b = h_shifted[5];
	assign o_vert_start_pulse = r.vst_out;
	assign o_vert_clock_pulse = r.vck_out;
	assign o_line_enable_pulse = r.enb_out;
	assign o_frame_inversion_pulse = r.frp_out;
	assign o_frame_inversion_complement = r.frame_inversion_complement_out;

endmodule : lcd_vac_timing

// ### design/lcd_vac_consts.svh
// Register indices, field positions, reset values and timing counts of the
// vertical drive and AC-conversion timing block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LCD_VAC_CONSTS_SVH
`define LCD_VAC_CONSTS_SVH

// Register indices; the Wishbone byte address is four times the index.
`define IDX_TRANS_LINK    14'h1000
`define IDX_POL_MODE      14'h1001
`define IDX_POL_FIX       14'h1002
`define IDX_INV_POS_A     14'h100E
`define IDX_INV_POS_B     14'h100F
`define IDX_SH_PHASE      14'h1015
`define IDX_VPOS_UPPER    14'h1021
`define IDX_VCK_POS_LOW   14'h1024
`define IDX_VST_POS_LOW   14'h1025
`define IDX_GATE_A        14'h102C
`define IDX_GATE_B        14'h102D
`define IDX_STATUS        14'h1030

// Field positions.
`define BIT_SHARE         0
`define BIT_MODE_HI       1
`define BIT_MODE_LO       0
`define BIT_VST_POL       2
`define BIT_VCK_POL       3
`define BIT_VST_FIX       0
`define BIT_VCK_FIX       1
`define BIT_INV_OE        0
`define BIT_COMP_OE       1
`define BIT_VOE           0

// Reset values.
`define RST_MODE          2'h3
`define RST_BYTE          8'h00

// Timing counts.
`define LINE_REF_DOTS     3'h5
`define SHP_STEPS         64
`define HCOUNT_W          11

`endif

// ### design/lcd_vac_pkg.sv
// Types shared by the vertical drive and AC-conversion timing modules.
// Assumes the constants header is on the include path.
`include "lcd_vac_consts.svh"

package lcd_vac_pkg;

	typedef enum logic [1:0] {
		SYNC_WAIT  = 2'b01,
		SYNC_DELAY = 2'b10
	} sync_e;

	typedef struct packed {
		logic                  hs_meta;
		logic                  hs_sync;
		logic                  hs_prev;
		logic                  vs_meta;
		logic                  vs_sync;
		logic                  vs_prev;
		logic                  vs_seen;
		logic                  dn_meta;
		logic                  dn_sync;
		logic                  div;
		logic                  dot_en;
		sync_e                 st;
		logic [2:0]            dly;
		logic [`HCOUNT_W-1:0]  hcount;
		logic                  line_ref;
		logic                  frame_line;
	} lineref_s;

	typedef struct packed {
		logic [`SHP_STEPS-1:0][5:0] taps;
		logic [5:0]                 out;
	} hphase_s;

	typedef struct packed {
		logic        wb_ack;
		logic [31:0] wb_dat;
		logic        share;
		logic [1:0]  mode;
		logic        vst_pol;
		logic        vck_pol;
		logic        vst_fix;
		logic        vck_fix;
		logic [9:0]  inv_pos;
		logic [5:0]  sample_hold_phase;
		logic [9:0]  vck_pos;
		logic [9:0]  vst_pos;
		logic        inv_oe;
		logic        comp_oe;
		logic        output_gate_b;
		logic        vst_pend;
		logic        vst_raw;
		logic        vck_raw;
		logic        frp_raw;
		logic        line_par;
		logic [1:0]  frame_cnt;
		logic [10:0] hck_cnt;
		logic        hck;
		logic        vst_out;
		logic        vck_out;
		logic        enb_out;
		logic        frp_out;
		logic        frame_inversion_complement_out;
	} core_s;

endpackage : lcd_vac_pkg

// ### design/lcd_vac_line_if.sv
// Line timing carried from the line reference module to the core.
// Assumes both ends run on the one master clock.
`timescale 1ns/1ps
`include "lcd_vac_consts.svh"

interface lcd_vac_line_if;
	logic                  dot_en;
	logic                  line_ref;
	logic                  frame_line;
	logic                  scan_dir;
	logic [`HCOUNT_W-1:0]  hcount;

	modport src  (output dot_en, line_ref, frame_line, scan_dir, hcount);
	modport sink (input  dot_en, line_ref, frame_line, scan_dir, hcount);
endinterface : lcd_vac_line_if

// ### design/lcd_vac_lineref.sv
// Line reference: synchronises the sync and direction pins, divides the
// master clock to the dot rate and runs the per-line dot counter.
// Assumes pins are asynchronous to i_mclk.
`timescale 1ns/1ps
`include "lcd_vac_consts.svh"

module lcd_vac_lineref (
	// Clock and reset
	input  wire logic     i_mclk,
	input  wire logic     i_reset,
	// Pins
	input  wire logic     i_horiz_sync_input,
	input  wire logic     i_vsync,
	input  wire logic     i_scan_direction,
	// Line timing
	lcd_vac_line_if.src   line
);

	lcd_vac_pkg::lineref_s r;
	lcd_vac_pkg::lineref_s n;

	always_comb begin
		n = r;
		n.hs_meta = i_horiz_sync_input;
		n.hs_sync = r.hs_meta;
		n.hs_prev = r.hs_sync;
		n.vs_meta = i_vsync;
		n.vs_sync = r.vs_meta;
		n.vs_prev = r.vs_sync;
		n.dn_meta = i_scan_direction;
		n.dn_sync = r.dn_meta;
		n.div = ~r.div;
		n.dot_en = r.div;
		n.line_ref = 1'b0;
		n.frame_line = 1'b0;
		if (r.dot_en && (r.hcount != {`HCOUNT_W{1'b1}})) begin
			n.hcount = r.hcount + `HCOUNT_W'(1);
		end
		case (r.st)
			lcd_vac_pkg::SYNC_WAIT: begin
			end
			lcd_vac_pkg::SYNC_DELAY: begin
				if (r.dot_en) begin
					n.dly = r.dly + 3'h1;
					if (r.dly == (`LINE_REF_DOTS - 3'h1)) begin
						n.st = lcd_vac_pkg::SYNC_WAIT;
						n.line_ref = 1'b1;
						n.hcount = '0;
						n.frame_line = r.vs_seen;
						n.vs_seen = 1'b0;
					end
				end
			end
			default: begin
				n.st = lcd_vac_pkg::SYNC_WAIT;
			end
		endcase
		// A frame edge arriving as the flag is consumed is kept.
		if (r.vs_sync && !r.vs_prev) begin
			n.vs_seen = 1'b1;
		end
		if (r.hs_sync && !r.hs_prev) begin
			n.st = lcd_vac_pkg::SYNC_DELAY;
			n.dly = 3'h0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			// The counter starts parked at its end, so no pulse timed from it is made
			// until the first line reference.
			r <= '{st: lcd_vac_pkg::SYNC_WAIT, hcount: '1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign line.dot_en = r.dot_en;
	assign line.line_ref = r.line_ref;
	assign line.frame_line = r.frame_line;
	assign line.scan_dir = r.dn_sync;
	assign line.hcount = r.hcount;

endmodule : lcd_vac_lineref

// ### design/lcd_vac_hphase.sv
// Half-dot phase shifter for the six horizontal transfer pulses.
// Assumes one master clock cycle is half a dot.
`timescale 1ns/1ps
`include "lcd_vac_consts.svh"

module lcd_vac_hphase (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// Pulses and phase
	input  wire logic [5:0]  i_pulses,
	input  wire logic [5:0]  i_shp,
	output logic      [5:0]  o_pulses
);

	lcd_vac_pkg::hphase_s r;
	lcd_vac_pkg::hphase_s n;

	// All six pulses share one tap, so their mutual phase never changes.
	always_comb begin
		n = r;
		n.taps = {r.taps[`SHP_STEPS-2:0], i_pulses};
		n.out = r.taps[~i_shp];
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_pulses = r.out;

endmodule : lcd_vac_hphase

// ### verif/lcd_vac_timing_chk.sv
// Concurrent checks on the ports of the timing block.
// Assumes binding to lcd_vac_timing with matching parameters.
`timescale 1ns/1ps
module lcd_vac_timing_chk #(
	parameter logic [10:0] HCK_HALF_DOTS = 11'h006,
	parameter logic [10:0] ENB_DOTS      = 11'h010
) (
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_horiz_sync_input,
	input wire logic        o_horiz_start_pulse,
	input wire logic        o_precharge_start_pulse,
	input wire logic        o_horiz_clock_a,
	input wire logic        o_horiz_clock_b,
	input wire logic        o_data_clock_a,
	input wire logic        o_data_clock_b,
	input wire logic        o_line_enable_pulse,
	input wire logic        o_frame_inversion_pulse,
	input wire logic        o_frame_inversion_complement
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	logic [11:0] enb_run;
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_sync_rise;
		$rose(i_horiz_sync_input);
	endsequence
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset)
			enb_run <= 12'h000;
		else
			enb_run <= o_line_enable_pulse ? enb_run + 12'h001 : 12'h000;
	end
	////////////////////////////////////////
	chk_ack_follows_req: assert property (s_req |=> o_wb_ack)
		else $error("ack missing after request");
	chk_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	chk_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_pair_exclusive: assert property (
		!(o_frame_inversion_pulse && o_frame_inversion_complement))
		else $error("inversion pair both high");
	chk_data_clock_copy: assert property (
		o_data_clock_a == o_horiz_clock_a && o_data_clock_b == o_horiz_clock_b)
		else $error("data clocks lost phase to horizontal clocks");
	chk_precharge_lag: assert property ($rose(o_horiz_start_pulse) |->
		(!o_precharge_start_pulse)[*8] ##5 $rose(o_precharge_start_pulse))
		else $error("precharge start not twelve cycles after start");
	chk_enable_width: assert property (
		o_line_enable_pulse |-> enb_run < {ENB_DOTS, 1'b0})
		else $error("line enable too long");
	chk_quiet_after_sync: assert property (
		s_sync_rise |=> (!o_line_enable_pulse)[*8])
		else $error("line enable too soon after sync");
	chk_enable_after_sync: assert property ($rose(o_line_enable_pulse) |->
		$past(i_horiz_sync_input, 8) && !$past(i_horiz_sync_input, 16))
		else $error("line enable not timed from sync");
endmodule : lcd_vac_timing_chk

// ### verif/lcd_panel_model.sv
// Panel-side model: stamps the first edge of each pulse in a line, except the horizontal clocks, which it checks are opposite.
// Assumes i_line_mark pulses for one cycle as each line sync rises.
`timescale 1ns/1ps
module lcd_panel_model (
	// Clock and line marker
	input  wire logic i_mclk,
	input  wire logic i_line_mark,
	// Pins from the timing block
	input  wire logic i_hst,
	input  wire logic i_pst,
	input  wire logic i_hck_a,
	input  wire logic i_hck_b,
	input  wire logic i_vst,
	input  wire logic i_vck,
	input  wire logic i_enb,
	input  wire logic i_frp,
	// Cycle of each first edge in the line, -1 if none; o_hck_ok clears if the clocks match
	output int        o_t_enb,
	output int        o_t_hst,
	output int        o_t_pst,
	output int        o_t_vst,
	output int        o_t_vck,
	output int        o_t_frp,
	output logic      o_hck_ok
);
	int         t;
	logic [5:0] q;
	always @(posedge i_mclk) begin
		q <= {i_frp, i_vck, i_vst, i_pst, i_hst, i_enb};
		if (i_line_mark) begin
			t <= 0;
			o_t_enb <= -1;
			o_t_hst <= -1;
			o_t_pst <= -1;
			o_t_vst <= -1;
			o_t_vck <= -1;
			o_t_frp <= -1;
			o_hck_ok <= 1'b1;
		end else begin
			t <= t + 1;
			if (i_enb && !q[0] && o_t_enb < 0) o_t_enb <= t;
			if (i_hst && !q[1] && o_t_hst < 0) o_t_hst <= t;
			if (i_pst && !q[2] && o_t_pst < 0) o_t_pst <= t;
			if (i_vst !== q[3] && o_t_vst < 0) o_t_vst <= t;
			if (i_vck !== q[4] && o_t_vck < 0) o_t_vck <= t;
			if (i_frp !== q[5] && o_t_frp < 0) o_t_frp <= t;
			if (i_hck_a === i_hck_b) o_hck_ok <= 1'b0;
		end
	end
endmodule : lcd_panel_model

// ### verif/lcd_vac_timing_tb_top.sv
// Self-checking bench for the vertical drive and AC-conversion block.
// Assumes the design, panel model and checker are compiled first.
`timescale 1ns/1ps
module lcd_vac_timing_tb_top;
	logic        clk, rst, cyc, stb, we, hs, vs, dn, mk;
	logic [15:0] adr;
	logic [31:0] wd, rd;
	logic [3:0]  sel;
	logic [5:0]  hp;
	logic        ack, vert_start_pulse, vert_clock_pulse, line_enable_pulse, frame_inversion_pulse, frame_inversion_complement, hok;
	int          fails, num_checks, te, th, tp, tv, tc, tf;
	// Edge logic acts at the end of the matching dot and is registered
	// once more, two cycles behind the line enable.
	localparam int EDGE_LAG = 2;
	logic [13:0] ri [11] = '{14'h1000, 14'h1001, 14'h1002, 14'h100E,
		14'h100F, 14'h1015, 14'h1021, 14'h1024, 14'h1025, 14'h102C, 14'h102D};
	logic [7:0]  rm [11] = '{8'h01, 8'h0F, 8'h03, 8'hFF, 8'h03, 8'h3F,
		8'h0F, 8'hFF, 8'hFF, 8'h03, 8'h01};
	lcd_vac_timing i_lcd_vac_timing (
		.i_mclk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(sel),
		.o_wb_dat(rd), .o_wb_ack(ack), .i_horiz_sync_input(hs),
		.i_vsync(vs), .i_scan_direction(dn), .o_horiz_start_pulse(hp[0]),
		.o_precharge_start_pulse(hp[1]), .o_horiz_clock_a(hp[2]),
		.o_horiz_clock_b(hp[3]), .o_data_clock_a(hp[4]),
		.o_data_clock_b(hp[5]), .o_vert_start_pulse(vert_start_pulse),
		.o_vert_clock_pulse(vert_clock_pulse), .o_line_enable_pulse(line_enable_pulse),
		.o_frame_inversion_pulse(frame_inversion_pulse), .o_frame_inversion_complement(frame_inversion_complement));
	lcd_panel_model i_panel (
		.i_mclk(clk), .i_line_mark(mk), .i_hst(hp[0]), .i_pst(hp[1]),
		.i_hck_a(hp[2]), .i_hck_b(hp[3]), .i_vst(vert_start_pulse), .i_vck(vert_clock_pulse),
		.i_enb(line_enable_pulse), .i_frp(frame_inversion_pulse), .o_t_enb(te), .o_t_hst(th),
		.o_t_pst(tp), .o_t_vst(tv), .o_t_vck(tc), .o_t_frp(tf),
		.o_hck_ok(hok));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(logic w, logic [13:0] i, logic [7:0] d,
		output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		wd <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wr(logic [13:0] i, logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, i, d, q);
	endtask : wr
	task automatic rdc(string nm, logic [13:0] i, logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, i, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask : rdc
	// A frame starts with a sync pulse on the vertical pin before the line.
	task automatic line(logic fr);
		if (fr) begin
			vs <= 1'b1;
			repeat (6) @(posedge clk);
			vs <= 1'b0;
			repeat (6) @(posedge clk);
		end
		hs <= 1'b1;
		mk <= 1'b1;
		@(posedge clk);
		mk <= 1'b0;
		repeat (19) @(posedge clk);
		hs <= 1'b0;
		repeat (1300) @(posedge clk);
	endtask : line
	function automatic logic in3(int d, int c);
		return d >= c + EDGE_LAG - 1 && d <= c + EDGE_LAG + 1;
	endfunction : in3
	function automatic logic neg(int k);
		return k[2] ? !k[1] : k[1] != k[0];
	endfunction : neg
	task automatic conclude;
		if (fails == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		int p, qv, v, s, k, base, wt, bt;
		logic [7:0] d;
		logic f [8];
		{rst, cyc, stb, we, hs, vs, dn, mk} = 8'h80;
		adr = 16'h0000;
		wd = 32'h0;
		sel = 4'hF;
		fails = 0;
		num_checks = 0;
		d = 8'($urandom(32'h83FC));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (100) @(posedge clk);
		for (int i = 0; i < 11; i++) rdc("reset", ri[i], i == 1 ? 8'h03 : 8'h00);
		for (int i = 0; i < 22; i++) begin
			d = 8'($urandom);
			wr(ri[i % 11], d);
			rdc("readback", ri[i % 11], d & rm[i % 11]);
		end
		wr(14'h1003, 8'hFF);
		rdc("unmapped", 14'h1003, 8'h00);
		wr(14'h1000, 8'h00);
		sel <= 4'h0;
		wr(14'h1000, 8'hFF);
		sel <= 4'hF;
		rdc("byte lane", 14'h1000, 8'h00);
		wr(14'h102D, 8'h01);
		wr(14'h102C, 8'h03);
		for (int j = 0; j < 8; j++) begin
			k = j ^ 3;
			wr(14'h1002, {6'h0, {2{k[2]}}});
			wr(14'h1001, {4'h0, {2{k[1]}}, 2'h3});
			dn <= k[0];
			repeat (6) @(posedge clk);
			chk("vert start", neg(k), vert_start_pulse);
			chk("vert clock", neg(k), vert_clock_pulse);
			chk("complement", 1, frame_inversion_complement);
		end
		wr(14'h102D, 8'h00);
		wr(14'h102C, 8'h01);
		repeat (2) @(posedge clk);
		chk("vert gated", 0, {vert_start_pulse, vert_clock_pulse});
		chk("complement gated", 0, frame_inversion_complement);
		wr(14'h102D, 8'h01);
		wr(14'h102C, 8'h03);
		wr(14'h1002, 8'h03);
		wr(14'h1001, 8'h0C);
		for (int j = 0; j < 3; j++) begin
			p = j == 0 ? 0 : $urandom_range(500, 1);
			qv = $urandom_range(500, 0);
			v = j == 0 ? 0 : $urandom_range(250, 1);
			s = j == 0 ? 0 : j == 1 ? 63 : $urandom_range(62, 1);
			wr(14'h1000, 8'(j == 2));
			wr(14'h1024, p[7:0]);
			wr(14'h100E, qv[7:0]);
			wr(14'h100F, 8'(qv >> 8));
			wr(14'h1025, v[7:0]);
			wr(14'h1021, {4'h0, v[9:8], p[9:8]});
			wr(14'h1015, 8'(s));
			line(1'b1);
			chk("start rise", 1, in3(tv - te, 4 * v + 4));
			line(1'b0);
			chk("start fall", 1, in3(tv - te, 4 * v + 4));
			chk("clock pos", 1, in3(tc - te, 2 * (j == 2 ? qv : p) + 2));
			chk("inversion pos", 1, in3(tf - te, 2 * qv + 2));
			chk("clock pair", 1, hok);
			chk("precharge lag", 12, tp - th);
			if (j == 0) base = th - te;
			chk("phase shift", base - s, th - te);
		end
		for (int m = 0; m < 4; m++) begin
			wr(14'h1001, 8'h0C | 8'(m));
			wt = 0;
			bt = 0;
			for (int j = 0; j < 8; j++) begin
				line(j % 2 == 0);
				f[j] = frame_inversion_pulse;
				if (j % 2 == 1) wt += int'(f[j] !== f[j - 1]);
				if (j > 1 && j % 2 == 0) bt += int'(f[j] !== f[j - 2]);
			end
			chk("line toggles", m[1] ? 0 : 4, wt);
			chk("frame toggles", 1, m[0] ? bt inside {1, 2} : bt == 3);
		end
		wr(14'h102D, 8'h00);
		wr(14'h102C, 8'h02);
		line(1'b0);
		chk("enable gated", 32'hFFFFFFFF, te);
		chk("clock gated", 0, vert_clock_pulse);
		chk("inversion gated", 0, frame_inversion_pulse);
		conclude();
	end
endmodule : lcd_vac_timing_tb_top
bind lcd_vac_timing lcd_vac_timing_chk #(
	.HCK_HALF_DOTS(HCK_HALF_DOTS),
	.ENB_DOTS(ENB_DOTS)
) i_chk (.i_mclk, .i_reset, .i_wb_cyc, .i_wb_stb, .o_wb_dat, .o_wb_ack,
	.i_horiz_sync_input, .o_horiz_start_pulse, .o_precharge_start_pulse,
	.o_horiz_clock_a, .o_horiz_clock_b, .o_data_clock_a, .o_data_clock_b,
	.o_line_enable_pulse, .o_frame_inversion_pulse,
	.o_frame_inversion_complement);
